// >>> logic/tim_pkg.sv
// Constants for the tag integrity and margin-verify logic
package tim_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] OPCODE = 16'hE001;
    localparam logic [1:0] BANK_RES = 2'h0;
    localparam logic [1:0] BANK_EPC = 2'h1;
    localparam logic [1:0] BANK_TID = 2'h2;
    localparam logic [1:0] BANK_USER = 2'h3;
    localparam logic [7:0] ERR_OTHER = 8'h00;
    localparam logic [7:0] ERR_LOCKED = 8'h04;
    localparam logic [7:0] ERR_POWER = 8'h0B;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;
    localparam logic [15:0] SCAN_EPC_LAST = 16'h007F;
    localparam logic [15:0] SCAN_RES_LAST = 16'h003F;
    localparam logic [15:0] TID_SER_FIRST = 16'h0030;
    localparam logic [15:0] TID_SER_LAST = 16'h005F;
    localparam logic [15:0] KILL_LAST = 16'h001F;
    localparam logic [15:0] ACCESS_LAST = 16'h003F;
    localparam logic [7:0] OP_BITS = 8'h10;
    localparam logic [7:0] LEN_BITS = 8'h08;
    localparam logic [7:0] EBV_LAST = 8'h07;
    localparam logic [7:0] HANDLE_BITS = 8'h10;
    localparam logic [7:0] CRC_BITS = 8'h10;
endpackage

// >>> logic/tim_check.sv
// Power-up memory self-check and margin-verify command execution
`timescale 1ns/1ns
module tim_check (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_frame_end,
    input wire logic [15:0] held_handle,
    input wire logic state_open,
    input wire logic state_secured,
    input wire logic power_ok,
    input wire logic query_trext,
    input wire logic kill_read_locked,
    input wire logic access_read_locked,
    input wire logic mem_bit,
    input wire logic mem_margin_ok,
    output logic mem_rd_en,
    output logic [1:0] mem_bank,
    output logic [15:0] mem_addr,
    output logic scan_done,
    output logic weak_flag,
    output logic epc_zero_len,
    output logic tid_parity_err,
    output logic tx_start,
    output logic tx_header,
    output logic [7:0] tx_code,
    output logic [15:0] tx_handle,
    output logic tx_trext
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [9:0] {
        ST_SCAN = 10'h001,
        ST_SCANW = 10'h002,
        ST_IDLE = 10'h004,
        ST_OP = 10'h008,
        ST_BANK = 10'h010,
        ST_PTR = 10'h020,
        ST_LEN = 10'h040,
        ST_MASK = 10'h080,
        ST_HANDLE = 10'h100,
        ST_CRC = 10'h200
    } tim_state_t;
    function automatic logic [15:0] tim_crc_step(input logic [15:0] crc, input logic b);
        logic fb;
        fb = crc[15] ^ b;
        tim_crc_step = {crc[14:0], 1'b0} ^ (fb ? tim_pkg::CRC_POLY : 16'h0000);
    endfunction
    tim_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [15:0] sh_reg;
    logic [15:0] crc_reg;
    logic [15:0] ptr_reg;
    logic [7:0] len_reg;
    logic [1:0] bank_reg;
    logic ebv_ext_reg;
    logic mask_bit_reg;
    logic rd_pend_reg;
    logic cmp_fail_reg;
    logic lock_fail_reg;
    logic parity_reg;
    logic [1:0] rd_bank_reg;
    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire parsing = (state_reg != ST_SCAN) && (state_reg != ST_SCANW) && (state_reg != ST_IDLE);
    wire take_bit = rx_bit_valid && parsing;
    wire [15:0] sh_next = {sh_reg[14:0], rx_bit};
    wire [15:0] cmp_addr = ptr_reg + {8'h00, cnt_reg};
    wire addr_kill = cmp_addr <= tim_pkg::KILL_LAST;
    wire addr_access = !addr_kill && (cmp_addr <= tim_pkg::ACCESS_LAST);
    wire lock_hit = (bank_reg == tim_pkg::BANK_RES) &&
                    ((addr_kill && kill_read_locked) || (addr_access && access_read_locked));
    wire scan_last_bit = (mem_bank == tim_pkg::BANK_TID) && (mem_addr == tim_pkg::TID_SER_LAST);
    wire state_ok = state_open || state_secured;
    // Frame must end right after the CRC field; anything else is noise
    wire frame_good = (state_reg == ST_CRC) && (cnt_reg == tim_pkg::CRC_BITS) &&
                      (crc_reg == tim_pkg::CRC_RESIDUE) && (len_reg != 8'h00) &&
                      (sh_reg == held_handle) && state_ok;
    wire bank_ro = bank_reg == tim_pkg::BANK_TID;
    wire [7:0] err_code = !power_ok ? tim_pkg::ERR_POWER :
                          lock_fail_reg ? tim_pkg::ERR_LOCKED :
                          tim_pkg::ERR_OTHER;
    wire is_err = !power_ok || lock_fail_reg || cmp_fail_reg || bank_ro;

    ////////////////////////////////////////////////////////////////////////
    // Memory port and power-up scan
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_rd_en <= 1'b0;
            mem_bank <= tim_pkg::BANK_EPC;
            mem_addr <= 16'h0000;
        end else if (state_reg == ST_SCAN) begin
            mem_rd_en <= 1'b1;
            if (!mem_rd_en) begin
                mem_addr <= 16'h0000;
            end else if (mem_bank == tim_pkg::BANK_EPC && mem_addr == tim_pkg::SCAN_EPC_LAST) begin
                mem_bank <= tim_pkg::BANK_RES;
                mem_addr <= 16'h0000;
            end else if (mem_bank == tim_pkg::BANK_RES && mem_addr == tim_pkg::SCAN_RES_LAST) begin
                mem_bank <= tim_pkg::BANK_TID;
                mem_addr <= tim_pkg::TID_SER_FIRST;
            end else if (scan_last_bit) begin
                mem_rd_en <= 1'b0;
            end else begin
                mem_addr <= mem_addr + 16'h0001;
            end
        end else if (state_reg == ST_MASK && take_bit && !bank_ro) begin
            mem_rd_en <= 1'b1;
            mem_bank <= bank_reg;
            mem_addr <= cmp_addr;
        end else begin
            mem_rd_en <= 1'b0;
        end
    end

    // Read data arrives one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= mem_rd_en;
            rd_bank_reg <= mem_bank; // Mem_bank still holds the bank of this strobe's read
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            weak_flag <= 1'b0;
            parity_reg <= 1'b0;
        end else if (rd_pend_reg && !scan_done) begin
            if (rd_bank_reg == tim_pkg::BANK_TID) begin
                parity_reg <= parity_reg ^ mem_bit;
            end else if (!mem_margin_ok) begin
                weak_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scan_done <= 1'b0;
            epc_zero_len <= 1'b0;
            tid_parity_err <= 1'b0;
        end else begin
            scan_done <= scan_done || (state_reg == ST_SCANW && !rd_pend_reg);
            epc_zero_len <= weak_flag;
            tid_parity_err <= scan_done && parity_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame parser
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_SCAN;
            cnt_reg <= 8'h00;
            sh_reg <= 16'h0000;
            crc_reg <= tim_pkg::CRC_PRESET;
            ptr_reg <= 16'h0000;
            len_reg <= 8'h00;
            bank_reg <= tim_pkg::BANK_RES;
            ebv_ext_reg <= 1'b0;
        end else if (state_reg == ST_SCAN) begin
            if (mem_rd_en && scan_last_bit) begin
                state_reg <= ST_SCANW;
            end
        end else if (state_reg == ST_SCANW) begin
            if (scan_done) begin
                state_reg <= ST_IDLE;
            end
        end else if (rx_frame_start) begin
            state_reg <= ST_OP;
            cnt_reg <= 8'h00;
            sh_reg <= 16'h0000;
            crc_reg <= tim_pkg::CRC_PRESET;
            ptr_reg <= 16'h0000;
        end else if (rx_frame_end) begin
            state_reg <= ST_IDLE;
        end else if (take_bit) begin
            crc_reg <= tim_crc_step(crc_reg, rx_bit);
            cnt_reg <= cnt_reg + 8'h01;
            case (state_reg)
                ST_OP: begin
                    sh_reg <= sh_next;
                    if (cnt_reg == tim_pkg::OP_BITS - 8'h01) begin
                        cnt_reg <= 8'h00;
                        state_reg <= (sh_next == tim_pkg::OPCODE) ? ST_BANK : ST_IDLE;
                    end
                end
                ST_BANK: begin
                    bank_reg <= {bank_reg[0], rx_bit};
                    if (cnt_reg == 8'h01) begin
                        cnt_reg <= 8'h00;
                        state_reg <= ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (cnt_reg == 8'h00) begin
                        ebv_ext_reg <= rx_bit;
                    end else begin
                        ptr_reg <= {ptr_reg[14:0], rx_bit};
                    end
                    if (cnt_reg == tim_pkg::EBV_LAST) begin
                        cnt_reg <= 8'h00;
                        state_reg <= ebv_ext_reg ? ST_PTR : ST_LEN;
                    end
                end
                ST_LEN: begin
                    len_reg <= sh_next[7:0];
                    sh_reg <= sh_next;
                    if (cnt_reg == tim_pkg::LEN_BITS - 8'h01) begin
                        cnt_reg <= 8'h00;
                        state_reg <= (sh_next[7:0] == 8'h00) ? ST_IDLE : ST_MASK;
                    end
                end
                ST_MASK: begin
                    if (cnt_reg == len_reg - 8'h01) begin
                        cnt_reg <= 8'h00;
                        state_reg <= ST_HANDLE;
                    end
                end
                ST_HANDLE: begin
                    sh_reg <= sh_next;
                    if (cnt_reg == tim_pkg::HANDLE_BITS - 8'h01) begin
                        cnt_reg <= 8'h00;
                        state_reg <= ST_CRC;
                    end
                end
                ST_CRC: begin
                    if (cnt_reg == tim_pkg::CRC_BITS) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask comparison; a bit pair needs two cycles, so rx bits come at least that far apart
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mask_bit_reg <= 1'b0;
            cmp_fail_reg <= 1'b0;
            lock_fail_reg <= 1'b0;
        end else if (rx_frame_start) begin
            cmp_fail_reg <= 1'b0;
            lock_fail_reg <= 1'b0;
        end else begin
            if (state_reg == ST_MASK && take_bit) begin
                mask_bit_reg <= rx_bit;
                lock_fail_reg <= lock_fail_reg || lock_hit;
            end
            if (rd_pend_reg && scan_done) begin
                cmp_fail_reg <= cmp_fail_reg || (mem_bit != mask_bit_reg) || !mem_margin_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_start <= 1'b0;
            tx_header <= 1'b0;
            tx_code <= tim_pkg::ERR_OTHER;
            tx_handle <= 16'h0000;
            tx_trext <= 1'b0;
        end else begin
            tx_start <= rx_frame_end && frame_good;
            if (rx_frame_end && frame_good) begin
                tx_header <= is_err;
                tx_code <= is_err ? err_code : tim_pkg::ERR_OTHER;
                tx_handle <= held_handle;
                tx_trext <= query_trext;
            end
        end
    end
endmodule

// >>> test/tim_check_monitor.sv
// Concurrent checks on the ports of the integrity and margin-verify block
`timescale 1ns/1ns
module tim_check_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rx_frame_end,
    input wire logic [15:0] held_handle,
    input wire logic state_open,
    input wire logic state_secured,
    input wire logic power_ok,
    input wire logic query_trext,
    input wire logic mem_rd_en,
    input wire logic weak_flag,
    input wire logic epc_zero_len,
    input wire logic tx_start,
    input wire logic tx_header,
    input wire logic [7:0] tx_code,
    input wire logic [15:0] tx_handle,
    input wire logic tx_trext
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_low_end;
        rx_frame_end && !power_ok;
    endsequence
    sequence s_reply;
        s_low_end ##1 tx_start;
    endsequence
    property p_scan; $rose(rst_n) |-> ##[1:3] mem_rd_en; endproperty
    a_scan: assert property (p_scan) else $error("scan not started");
    property p_sticky; weak_flag |=> weak_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("weak flag dropped");
    property p_zlen; 1'h1 |=> epc_zero_len == $past(weak_flag); endproperty
    a_zlen: assert property (p_zlen) else $error("zero length not tracking");
    property p_cause; tx_start |-> $past(rx_frame_end) ##1 !tx_start; endproperty
    a_cause: assert property (p_cause) else $error("reply without frame");
    property p_state; rx_frame_end && !state_open && !state_secured |=> !tx_start; endproperty
    a_state: assert property (p_state) else $error("reply in wrong state");
    property p_power; s_reply |-> tx_header && tx_code == tim_pkg::ERR_POWER; endproperty
    a_power: assert property (p_power) else $error("power code missing");
    property p_pass; tx_start && !tx_header |-> tx_code == 8'h00 && tx_handle == held_handle; endproperty
    a_pass: assert property (p_pass) else $error("bad pass reply");
    property p_trext; tx_start |-> tx_trext == $past(query_trext); endproperty
    a_trext: assert property (p_trext) else $error("preamble choice wrong");
    property p_hold; !tx_start |-> $stable(tx_code) && $stable(tx_header); endproperty
    a_hold: assert property (p_hold) else $error("reply fields moved");
endmodule

// >>> test/tim_reader.sv
// Reader model that sends margin-verify frames bit by bit
`timescale 1ns/1ns
module tim_reader (
    input wire logic clock,
    output logic rx_frame_start,
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic rx_frame_end
);
    logic q[$];
    logic [15:0] crc;
    initial begin
        rx_frame_start = 1'h0;
        rx_bit_valid = 1'h0;
        rx_bit = 1'h0;
        rx_frame_end = 1'h0;
    end
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic push(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) q.push_back(v[i]);
    endtask
    // Fields in fixed order, CRC inverted so the residue lands
    task automatic send(input logic [15:0] op, input logic [1:0] bank, input logic [7:0] ptr,
        input logic [7:0] len, input logic [31:0] mask, input logic [15:0] hdl);
        q = {};
        push(32'(op), 16);
        push(32'(bank), 2);
        push({25'h0, ptr[6:0]}, 8);
        push(32'(len), 8);
        push(mask, int'(len));
        push(32'(hdl), 16);
        crc = 16'hFFFF;
        foreach (q[i]) crc = {crc[14:0], 1'h0} ^ ((crc[15] ^ q[i]) ? 16'h1021 : 16'h0000);
        push(32'(~crc), 16);
        tick();
        rx_frame_start = 1'h1;
        tick();
        rx_frame_start = 1'h0;
        foreach (q[i]) begin
            rx_bit = q[i];
            rx_bit_valid = 1'h1;
            tick();
            rx_bit_valid = 1'h0;
            rx_bit = ~q[i];
            tick();
        end
        tick();
        rx_frame_end = 1'h1;
        tick();
        rx_frame_end = 1'h0;
    endtask
endmodule

// >>> test/tag_integrity_margin_check_bench.sv
// Self-checking bench for the integrity and margin-verify block
`timescale 1ns/1ns
module tag_integrity_margin_check_bench;
    logic clock, rst_n, rx_frame_start, rx_bit_valid, rx_bit, rx_frame_end, state_open;
    logic state_secured, power_ok, query_trext, kill_read_locked, access_read_locked;
    logic mem_bit, mem_margin_ok, mem_rd_en, scan_done, weak_flag, epc_zero_len;
    logic tid_parity_err, tx_start, tx_header, tx_trext, weak_epc, tid_odd;
    logic [1:0] mem_bank;
    logic [7:0] tx_code;
    logic [15:0] held_handle, mem_addr, tx_handle;
    int err_count = 0;
    int total_checks = 0;
    tim_check dut_u (.clock, .rst_n, .rx_frame_start, .rx_bit_valid, .rx_bit, .rx_frame_end,
        .held_handle, .state_open, .state_secured, .power_ok, .query_trext, .kill_read_locked,
        .access_read_locked, .mem_bit, .mem_margin_ok, .mem_rd_en, .mem_bank, .mem_addr,
        .scan_done, .weak_flag, .epc_zero_len, .tid_parity_err, .tx_start, .tx_header,
        .tx_code, .tx_handle, .tx_trext);
    tim_reader rdr_u (.clock, .rx_frame_start, .rx_bit_valid, .rx_bit, .rx_frame_end);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Memory answers one cycle after each read, then scrambles the line
    always @(posedge clock) begin
        logic [1:0] b;
        logic [15:0] a;
        logic en;
        b = mem_bank;
        a = mem_addr;
        en = mem_rd_en;
        #1;
        mem_bit = en ? (b == 2'h2 ? (a == 16'h0030) & tid_odd : (b[0] & (a[0] ^ a[3]))) : ~mem_bit;
        mem_margin_ok = !(a == 16'h0005 && ((b == 2'h1 && weak_epc) || b == 2'h3));
    end
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Reset held 20 cycles, then a bounded wait for the scan
    task automatic boot();
        rst_n = 1'h0;
        repeat (20) tick();
        rst_n = 1'h1;
        for (int i = 0; i < 400 && scan_done !== 1'h1; i++) tick();
        if (scan_done !== 1'h1) begin
            err_count++;
            finish_test();
        end
        // Parity flag settles one edge after scan_done
        repeat (2) tick();
    endtask
    task automatic frame(input logic [1:0] bank, input logic [7:0] ptr, input logic [7:0] len,
        input logic [31:0] mask, input logic silent, input logic hdr, input logic [7:0] code);
        logic seen;
        seen = 1'h0;
        rdr_u.send(16'hE001, bank, ptr, len, mask, 16'h5A3C);
        // Reply pulse already stands when send returns
        repeat (4) begin
            if (tx_start === 1'h1) begin
                seen = 1'h1;
                check({6'h00, tx_header, tx_code, tx_handle, tx_trext},
                    {6'h00, hdr, code, 16'h5A3C, query_trext});
            end
            tick();
        end
        check(32'(seen), 32'(!silent));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'h0;
        held_handle = 16'h5A3C;
        state_open = 1'h1;
        state_secured = 1'h0;
        power_ok = 1'h1;
        query_trext = 1'h1;
        kill_read_locked = 1'h0;
        access_read_locked = 1'h0;
        mem_bit = 1'h0;
        mem_margin_ok = 1'h1;
        weak_epc = 1'h1;
        tid_odd = 1'h1;
        for (int pass = 0; pass < 2; pass++) begin
            boot();
            check(32'(weak_flag), 32'(weak_epc));
            check(32'(epc_zero_len), 32'(weak_epc));
            check(32'(tid_parity_err), 32'(tid_odd));
            weak_epc = 1'h0;
            tid_odd = 1'h0;
        end
        $display("test power-up scan done");
        frame(2'h1, 8'h08, 8'h04, 32'hA, 1'h0, 1'h0, 8'h00);
        query_trext = 1'h0;
        frame(2'h1, 8'h08, 8'h04, 32'hB, 1'h0, 1'h1, 8'h00);
        frame(2'h3, 8'h04, 8'h02, 32'h1, 1'h0, 1'h1, 8'h00);
        frame(2'h2, 8'h30, 8'h01, 32'h0, 1'h0, 1'h1, 8'h00);
        power_ok = 1'h0;
        frame(2'h1, 8'h08, 8'h04, 32'hA, 1'h0, 1'h1, 8'h0B);
        power_ok = 1'h1;
        kill_read_locked = 1'h1;
        frame(2'h0, 8'h00, 8'h01, 32'h0, 1'h0, 1'h1, 8'h04);
        kill_read_locked = 1'h0;
        access_read_locked = 1'h1;
        frame(2'h0, 8'h20, 8'h01, 32'h0, 1'h0, 1'h1, 8'h04);
        access_read_locked = 1'h0;
        $display("test replies done");
        frame(2'h1, 8'h08, 8'h00, 32'h0, 1'h1, 1'h0, 8'h00);
        held_handle = 16'h5A3D;
        frame(2'h1, 8'h08, 8'h04, 32'hA, 1'h1, 1'h0, 8'h00);
        held_handle = 16'h5A3C;
        state_open = 1'h0;
        frame(2'h1, 8'h08, 8'h04, 32'hA, 1'h1, 1'h0, 8'h00);
        state_secured = 1'h1;
        frame(2'h1, 8'h08, 8'h04, 32'hA, 1'h0, 1'h0, 8'h00);
        $display("test silent drops done");
        finish_test();
    end
endmodule

bind tim_check tim_check_monitor mon_u (.clock, .rst_n, .rx_frame_end, .held_handle, .state_open,
    .state_secured, .power_ok, .query_trext, .mem_rd_en, .weak_flag, .epc_zero_len, .tx_start,
    .tx_header, .tx_code, .tx_handle, .tx_trext);
